// ===== src/bchr_regs.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// ----------------------------------------------------------------------------
module bchr_regs
    import bchr_pkg::*;
#(
    parameter int ADDR_W = BCHR_ADDR_W
)
(
    // Clock and reset
    input  wire logic              clk_sys,
    input  wire logic              resetn,
    // Register port
    input  wire logic [ADDR_W-1:0] reg_addr,
    input  wire logic [31:0]       reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic      [31:0]       reg_rdata,
    // Core status inputs
    input  wire logic              io_wide_addressing_flag,
    input  wire logic              cmd_serr_enable,
    input  wire logic              devctl_err_report_enable,
    // Secondary side events
    input  wire logic              sec_poison_seen,
    input  wire logic              sec_err_cor,
    input  wire logic              sec_err_nonfatal,
    input  wire logic              sec_err_fatal,
    // Window and control outputs
    output logic      [15:0]       io_base_high_half,
    output logic      [15:0]       io_limit_high_half,
    output logic                   vga_forward_enable,
    output logic                   secondary_hot_reset,
    // Primary side reports
    output logic                   poison_report,
    output logic                   fwd_err_cor,
    output logic                   fwd_err_nonfatal,
    output logic                   fwd_err_fatal,
    // Interrupt
    output logic                   irq
);

    // ------------------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------------------
    generate
        if (ADDR_W < 8)
        begin : g_bad_addr
            $error("bchr_regs: ADDR_W must be at least 8");
        end
    endgenerate

    // ------------------------------------------------------------------------
    // State
    // ------------------------------------------------------------------------
    typedef struct packed {
        logic [15:0] base_hi;
        logic [15:0] limit_hi;
        logic [7:0]  line;
        logic [7:0]  pin;
        logic        poison_en;
        logic        fwd_en;
        logic        vga_en;
        logic        hot_rst;
        logic [2:0]  evt_en;
        logic [31:0] rdata;
        logic [15:0] base_out;
        logic [15:0] limit_out;
        logic        poison_rpt;
        logic        f_cor;
        logic        f_nf;
        logic        f_fat;
        logic        irq;
    } bchr_st_s;

    localparam bchr_st_s ST_RST = '{
        base_hi:    RST_IO_BASE_HIGH_HALF,
        limit_hi:   RST_IO_LIMIT_HIGH_HALF,
        line:       RST_IRQ_LINE_VALUE,
        pin:        RST_IRQ_PIN_VALUE,
        poison_en:  RST_CTRL_BIT,
        fwd_en:     RST_CTRL_BIT,
        vga_en:     RST_CTRL_BIT,
        hot_rst:    RST_CTRL_BIT,
        evt_en:     RST_EVT,
        rdata:      32'h0000_0000,
        base_out:   16'h0000,
        limit_out:  16'h0000,
        poison_rpt: 1'b0,
        f_cor:      1'b0,
        f_nf:       1'b0,
        f_fat:      1'b0,
        irq:        1'b0
    };

    bchr_st_s        st_r;
    bchr_st_s        st_nxt;
    logic [7:0]      addr8;
    logic            fwd_ok;
    logic [2:0]      evt_set;
    logic [2:0]      evt_clr;
    logic [2:0]      evt_sts;
    logic [15:0]     ctrl_view;

    assign addr8 = reg_addr[7:0];

    // ------------------------------------------------------------------------
    // Event sources
    // ------------------------------------------------------------------------
    // error reporting gate
    // Forwarding needs both the control bit and a primary-side enable
    assign fwd_ok = st_r.fwd_en && (cmd_serr_enable || devctl_err_report_enable);

    // hot reset event
    // Event on the write that raises the hot reset bit, not while it stays high
    always_comb
    begin
        evt_set                = '0;
        evt_set[EVT_POISON]    = sec_poison_seen && st_r.poison_en;
        evt_set[EVT_ERR_FWD]   = fwd_ok && (sec_err_cor || sec_err_nonfatal || sec_err_fatal);
        evt_set[EVT_HOT_RESET] = st_nxt.hot_rst && !st_r.hot_rst;
    end

    // Write one to clear; a clear never hides an event of the same cycle
    assign evt_clr = (reg_wr && addr8 == OFS_EVT_CLEAR) ? reg_wdata[2:0] : 3'h0;

    bchr_sticky #(
        .W (BCHR_EVT_N)
    ) u_sticky (
        .clk_sys (clk_sys),
        .resetn  (resetn),
        .set     (evt_set),
        .clr     (evt_clr),
        .flags   (evt_sts)
    );

    // reserved zero
    // Only implemented control bits appear; the rest are constant zero
    always_comb
    begin
        ctrl_view                            = 16'h0000;
        ctrl_view[BC_POISON_RESPONSE_ENABLE] = st_r.poison_en;
        ctrl_view[BC_ERROR_FORWARD_ENABLE]   = st_r.fwd_en;
        ctrl_view[BC_VGA_FORWARD_ENABLE]     = st_r.vga_en;
        ctrl_view[BC_SECONDARY_HOT_RESET]    = st_r.hot_rst;
    end

    // ------------------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------------------
    // Writes, read mux and registered outputs
    always_comb
    begin
        st_nxt = st_r;
        if (reg_wr)
        begin
            unique case (addr8)
                OFS_IO_WINDOW_BASE_UPPER:
                begin
                    if (io_wide_addressing_flag)
                    begin
                        st_nxt.base_hi = reg_wdata[15:0];
                    end
                end
                OFS_IO_WINDOW_LIMIT_UPPER:
                begin
                    if (io_wide_addressing_flag)
                    begin
                        st_nxt.limit_hi = reg_wdata[15:0];
                    end
                end
                OFS_IRQ_ROUTING_LINE: st_nxt.line = reg_wdata[7:0];
                OFS_IRQ_PIN_SELECT:   st_nxt.pin  = reg_wdata[7:0];
                OFS_BRIDGE_CONTROL:
                begin
                    st_nxt.poison_en = reg_wdata[BC_POISON_RESPONSE_ENABLE];
                    st_nxt.fwd_en    = reg_wdata[BC_ERROR_FORWARD_ENABLE];
                    st_nxt.vga_en    = reg_wdata[BC_VGA_FORWARD_ENABLE];
                    st_nxt.hot_rst   = reg_wdata[BC_SECONDARY_HOT_RESET];
                end
                OFS_EVT_ENABLE:       st_nxt.evt_en = reg_wdata[2:0];
                default:              st_nxt.line   = st_r.line;
            endcase
        end

        // Read data stand only in the cycle after the strobe
        st_nxt.rdata = 32'h0000_0000;
        if (reg_rd)
        begin
            unique case (addr8)
                OFS_IO_WINDOW_BASE_UPPER:
                    st_nxt.rdata = io_wide_addressing_flag ? {16'h0000, st_r.base_hi} : '0;
                OFS_IO_WINDOW_LIMIT_UPPER:
                    st_nxt.rdata = io_wide_addressing_flag ? {16'h0000, st_r.limit_hi} : '0;
                OFS_CAPABILITY_LIST_HEAD: st_nxt.rdata = {24'h00_0000, VAL_CAPABILITY_LIST};
                OFS_OPTION_ROM_BASE:      st_nxt.rdata = VAL_OPTION_ROM_ADDRESS;
                OFS_IRQ_ROUTING_LINE:     st_nxt.rdata = {24'h00_0000, st_r.line};
                OFS_IRQ_PIN_SELECT:       st_nxt.rdata = {24'h00_0000, st_r.pin};
                OFS_BRIDGE_CONTROL:       st_nxt.rdata = {16'h0000, ctrl_view};
                OFS_EVT_STATUS:           st_nxt.rdata = {29'h0000_0000, evt_sts};
                OFS_EVT_ENABLE:           st_nxt.rdata = {29'h0000_0000, st_r.evt_en};
                default:                  st_nxt.rdata = 32'h0000_0000;
            endcase
        end

        // window halves masked
        // Mask the outputs but keep the stored value for when the flag returns
        st_nxt.base_out  = io_wide_addressing_flag ? st_r.base_hi : 16'h0000;
        st_nxt.limit_out = io_wide_addressing_flag ? st_r.limit_hi : 16'h0000;

        st_nxt.poison_rpt = sec_poison_seen && st_r.poison_en;
        st_nxt.f_cor = sec_err_cor && fwd_ok;
        st_nxt.f_nf  = sec_err_nonfatal && fwd_ok;
        st_nxt.f_fat = sec_err_fatal && fwd_ok;

        // Level interrupt; the pin select plays no part in it
        st_nxt.irq = |(evt_sts & st_r.evt_en);
    end

    // State register
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            st_r <= ST_RST;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    // ------------------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------------------
    assign reg_rdata           = st_r.rdata;
    assign io_base_high_half   = st_r.base_out;
    assign io_limit_high_half  = st_r.limit_out;
    assign vga_forward_enable  = st_r.vga_en;
    assign secondary_hot_reset = st_r.hot_rst;
    assign poison_report       = st_r.poison_rpt;
    assign fwd_err_cor         = st_r.f_cor;
    assign fwd_err_nonfatal    = st_r.f_nf;
    assign fwd_err_fatal       = st_r.f_fat;
    assign irq                 = st_r.irq;

    // ------------------------------------------------------------------------
    // Checks
    // ------------------------------------------------------------------------
    a_iohi_narrow_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
        (reg_rd && !io_wide_addressing_flag
            && (addr8 == OFS_IO_WINDOW_BASE_UPPER || addr8 == OFS_IO_WINDOW_LIMIT_UPPER))
        |=> (reg_rdata == 32'h0000_0000))
        else $error("narrow I/O upper half did not read zero");

    a_iohi_write_lock: assert property (@(posedge clk_sys) disable iff (!resetn)
        (reg_wr && !io_wide_addressing_flag
            && (addr8 == OFS_IO_WINDOW_BASE_UPPER || addr8 == OFS_IO_WINDOW_LIMIT_UPPER))
        |=> (st_r.base_hi == $past(st_r.base_hi) && st_r.limit_hi == $past(st_r.limit_hi)))
        else $error("locked I/O upper half took a write");

    a_capability_list_pointer_fixed: assert property (@(posedge clk_sys) disable iff (!resetn)
        (reg_rd && addr8 == OFS_CAPABILITY_LIST_HEAD) |=> (reg_rdata == 32'h0000_0040))
        else $error("capability pointer not 0x40");

    a_optrom_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
        (reg_rd && addr8 == OFS_OPTION_ROM_BASE) |=> (reg_rdata == 32'h0000_0000))
        else $error("option ROM base not zero");

    a_line_readback: assert property (@(posedge clk_sys) disable iff (!resetn)
        (reg_wr && addr8 == OFS_IRQ_ROUTING_LINE)
        ##1 !(reg_wr && addr8 == OFS_IRQ_ROUTING_LINE)
        ##1 (reg_rd && addr8 == OFS_IRQ_ROUTING_LINE)
        |=> (reg_rdata == {24'h00_0000, $past(reg_wdata[7:0], 3)}))
        else $error("interrupt line readback mismatch");

    a_poison_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
        sec_poison_seen |=> (poison_report == $past(st_r.poison_en)))
        else $error("poison report does not follow its enable");

    a_fwd_gate: assert property (@(posedge clk_sys) disable iff (!resetn)
        (sec_err_fatal || sec_err_cor)
        |=> ((fwd_err_fatal || fwd_err_cor) == $past(st_r.fwd_en
            && (cmd_serr_enable || devctl_err_report_enable))))
        else $error("error forwarding gate wrong");

    a_fwd_needs_rpt: assert property (@(posedge clk_sys) disable iff (!resetn)
        fwd_err_nonfatal |-> $past(cmd_serr_enable || devctl_err_report_enable))
        else $error("error forwarded without reporting enabled");

    a_isa_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
        (reg_rd && addr8 == OFS_BRIDGE_CONTROL) |=> !reg_rdata[2])
        else $error("ISA enable bit read as one");

    a_vga_follow: assert property (@(posedge clk_sys) disable iff (!resetn)
        (reg_wr && addr8 == OFS_BRIDGE_CONTROL)
        |=> (vga_forward_enable == $past(reg_wdata[3])))
        else $error("VGA forwarding does not follow control bit");

    a_hot_reset_set: assert property (@(posedge clk_sys) disable iff (!resetn)
        (reg_wr && addr8 == OFS_BRIDGE_CONTROL && reg_wdata[6] && !secondary_hot_reset)
        |=> secondary_hot_reset ##1 (irq || !$past(st_r.evt_en[EVT_HOT_RESET])))
        else $error("hot reset not raised by control write");

    a_rsvd_zero: assert property (@(posedge clk_sys) disable iff (!resetn)
        (reg_rd && addr8 == OFS_BRIDGE_CONTROL)
        |=> (reg_rdata[5:4] == 2'b00 && reg_rdata[31:7] == '0))
        else $error("reserved control bits not zero");

    a_irq_level: assert property (@(posedge clk_sys) disable iff (!resetn)
        ##1 (irq == $past(|(evt_sts & st_r.evt_en))))
        else $error("interrupt does not track enabled status");

endmodule : bchr_regs

// ===== include/bchr_pkg.sv
// ----------------------------------------------------------------------------
// Bridge configuration header registers: shared constants
// ----------------------------------------------------------------------------
package bchr_pkg;

    // ------------------------------------------------------------------------
    // Bus widths
    // ------------------------------------------------------------------------
    localparam int BCHR_ADDR_W = 8;
    localparam int BCHR_DATA_W = 32;
    localparam int BCHR_EVT_N  = 3;

    // ------------------------------------------------------------------------
    // Register byte offsets
    // ------------------------------------------------------------------------
    localparam logic [7:0] OFS_IO_WINDOW_BASE_UPPER  = 8'h30;
    localparam logic [7:0] OFS_IO_WINDOW_LIMIT_UPPER = 8'h32;
    localparam logic [7:0] OFS_CAPABILITY_LIST_HEAD  = 8'h34;
    localparam logic [7:0] OFS_OPTION_ROM_BASE       = 8'h38;
    localparam logic [7:0] OFS_IRQ_ROUTING_LINE      = 8'h3c;
    localparam logic [7:0] OFS_IRQ_PIN_SELECT        = 8'h3d;
    localparam logic [7:0] OFS_BRIDGE_CONTROL        = 8'h3e;
    localparam logic [7:0] OFS_EVT_STATUS            = 8'h80;
    localparam logic [7:0] OFS_EVT_CLEAR             = 8'h84;
    localparam logic [7:0] OFS_EVT_ENABLE            = 8'h88;

    // ------------------------------------------------------------------------
    // Values after reset and fixed values
    // ------------------------------------------------------------------------
    localparam logic [15:0] RST_IO_BASE_HIGH_HALF  = 16'hffff;
    localparam logic [15:0] RST_IO_LIMIT_HIGH_HALF = 16'h0000;
    localparam logic [7:0]  VAL_CAPABILITY_LIST    = 8'h40;
    localparam logic [31:0] VAL_OPTION_ROM_ADDRESS = 32'h0000_0000;
    localparam logic [7:0]  RST_IRQ_LINE_VALUE     = 8'h00;
    localparam logic [7:0]  RST_IRQ_PIN_VALUE      = 8'h00;
    localparam logic        RST_CTRL_BIT           = 1'b0;
    localparam logic [2:0]  RST_EVT                = 3'h0;

    // ------------------------------------------------------------------------
    // Bridge control field positions
    // ------------------------------------------------------------------------
    localparam int BC_POISON_RESPONSE_ENABLE = 0;
    localparam int BC_ERROR_FORWARD_ENABLE   = 1;
    localparam int BC_ISA_ADDRESSING_ENABLE  = 2;
    localparam int BC_VGA_FORWARD_ENABLE     = 3;
    localparam int BC_SECONDARY_HOT_RESET    = 6;

    // ------------------------------------------------------------------------
    // Event bit positions in status, clear and enable
    // ------------------------------------------------------------------------
    localparam int EVT_POISON    = 0;
    localparam int EVT_ERR_FWD   = 1;
    localparam int EVT_HOT_RESET = 2;

endpackage : bchr_pkg

// ===== src/bchr_sticky.sv
`timescale 1ns/1ps
// ----------------------------------------------------------------------------
// Sticky event flags, set wins over clear
// ----------------------------------------------------------------------------
module bchr_sticky
    import bchr_pkg::*;
#(
    parameter int W = BCHR_EVT_N
)
(
    // Clock and reset
    input  wire logic         clk_sys,
    input  wire logic         resetn,
    // Set and clear vectors
    input  wire logic [W-1:0] set,
    input  wire logic [W-1:0] clr,
    // Flags
    output logic      [W-1:0] flags
);

    typedef struct packed {
        logic [W-1:0] flg;
    } bchr_stk_s;

    bchr_stk_s st_r;
    bchr_stk_s st_nxt;

    // Set is applied last so a coincident event survives its clear
    always_comb
    begin
        st_nxt     = st_r;
        st_nxt.flg = (st_r.flg & ~clr) | set;
    end

    // State register
    always_ff @(posedge clk_sys or negedge resetn)
    begin
        if (!resetn)
        begin
            st_r.flg <= '0;
        end
        else
        begin
            st_r <= st_nxt;
        end
    end

    assign flags = st_r.flg;

    // A set in the same cycle as its clear leaves the flag set
    a_set_wins: assert property (@(posedge clk_sys) disable iff (!resetn)
        (set != '0) |=> ((flags & $past(set)) == $past(set)))
        else $error("sticky flag lost a set");

endmodule : bchr_sticky

// ===== verif/bchr_regs_tb_top.sv
`timescale 1ns/1ps
module bchr_regs_tb_top
    import bchr_pkg::*;
;
    // ------------------------------------------------------------------------
    // Signals
    // ------------------------------------------------------------------------
    logic        clk_sys, resetn, reg_wr, reg_rd, io_wide_addressing_flag;
    logic        cmd_serr_enable, devctl_err_report_enable, poison_report, irq;
    logic        fwd_err_cor, fwd_err_nonfatal, fwd_err_fatal;
    logic        vga_forward_enable, secondary_hot_reset;
    logic [7:0]  reg_addr;
    logic [31:0] reg_wdata, reg_rdata;
    logic [15:0] io_base_high_half, io_limit_high_half, lfsr_r;
    logic [3:0]  ev_v;
    logic [7:0]  addrs [12];
    int          n_fail, n_tests, cycles;
    // Behavioural model of the register file and event flags
    logic [15:0] m_base, m_lim, m_ctrl;
    logic [7:0]  m_line, m_pin;
    logic [2:0]  m_st, m_en;

    bchr_regs dut_u (.clk_sys(clk_sys), .resetn(resetn), .reg_addr(reg_addr),
        .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd), .reg_rdata(reg_rdata),
        .io_wide_addressing_flag(io_wide_addressing_flag), .cmd_serr_enable(cmd_serr_enable),
        .devctl_err_report_enable(devctl_err_report_enable), .sec_poison_seen(ev_v[0]),
        .sec_err_cor(ev_v[1]), .sec_err_nonfatal(ev_v[2]), .sec_err_fatal(ev_v[3]),
        .io_base_high_half(io_base_high_half), .io_limit_high_half(io_limit_high_half),
        .vga_forward_enable(vga_forward_enable), .secondary_hot_reset(secondary_hot_reset),
        .poison_report(poison_report), .fwd_err_cor(fwd_err_cor),
        .fwd_err_nonfatal(fwd_err_nonfatal), .fwd_err_fatal(fwd_err_fatal), .irq(irq));

    // ------------------------------------------------------------------------
    // Clock and hang guard
    // ------------------------------------------------------------------------
    initial
    begin
        clk_sys = 1'b0;
        forever #5 clk_sys = ~clk_sys;
    end
    // The whole run needs well under 2000 cycles; stop a stuck run here
    always @(posedge clk_sys)
    begin
        cycles++;
        if (cycles == 20000)
        begin
            n_fail++;
            conclude();
        end
    end

    // ------------------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------------------
    task automatic conclude();
        if (n_fail == 0 && n_tests > 0)
            $display("TB: PASS");
        else
            $display("TB: FAIL");
        $finish;
    endtask : conclude

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_tests++;
        if (seen !== exp)
        begin
            n_fail++;
            $display("BAD t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk

    // Two LFSR steps per call so successive words differ in most bits
    function automatic logic [31:0] rnd32();
        logic [31:0] v;
        v[15:0]  = lfsr_r;
        lfsr_r   = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
        v[31:16] = lfsr_r;
        lfsr_r   = {lfsr_r[14:0], lfsr_r[15] ^ lfsr_r[13] ^ lfsr_r[12] ^ lfsr_r[10]};
        return v;
    endfunction : rnd32

    // Expected read data, worked out from the model and io_wide_addressing_flag
    function automatic logic [31:0] exp_rd(input logic [7:0] a);
        case (a)
            OFS_IO_WINDOW_BASE_UPPER:  return io_wide_addressing_flag ? {16'h0, m_base} : 32'h0;
            OFS_IO_WINDOW_LIMIT_UPPER: return io_wide_addressing_flag ? {16'h0, m_lim} : 32'h0;
            OFS_CAPABILITY_LIST_HEAD:  return 32'h0000_0040;
            OFS_IRQ_ROUTING_LINE:      return {24'h0, m_line};
            OFS_IRQ_PIN_SELECT:        return {24'h0, m_pin};
            OFS_BRIDGE_CONTROL:        return {16'h0, m_ctrl};
            OFS_EVT_STATUS:            return {29'h0, m_st};
            OFS_EVT_ENABLE:            return {29'h0, m_en};
            default:                   return 32'h0;
        endcase
    endfunction : exp_rd

    // Bus write: one strobe cycle, then the model follows the same write
    task automatic wr(input logic [7:0] a, input logic [31:0] d);
        @(posedge clk_sys);
        reg_wr    <= 1'b1;
        reg_addr  <= a;
        reg_wdata <= d;
        @(posedge clk_sys);
        reg_wr <= 1'b0;
        case (a)
            OFS_IO_WINDOW_BASE_UPPER:  if (io_wide_addressing_flag) m_base = d[15:0];
            OFS_IO_WINDOW_LIMIT_UPPER: if (io_wide_addressing_flag) m_lim = d[15:0];
            OFS_IRQ_ROUTING_LINE:      m_line = d[7:0];
            OFS_IRQ_PIN_SELECT:        m_pin = d[7:0];
            OFS_BRIDGE_CONTROL:
            begin
                if (!m_ctrl[6] && d[6])
                    m_st[2] = 1'b1;
                m_ctrl = d[15:0] & 16'h004b;
            end
            OFS_EVT_CLEAR:             m_st = m_st & ~d[2:0];
            OFS_EVT_ENABLE:            m_en = d[2:0];
            default:                   ;
        endcase
    endtask : wr

    // Bus read: data is looked at only in the cycle after the strobe
    task automatic rd_chk(input logic [7:0] a);
        @(posedge clk_sys);
        reg_rd   <= 1'b1;
        reg_addr <= a;
        @(posedge clk_sys);
        reg_rd <= 1'b0;
        #1;
        chk(reg_rdata, exp_rd(a));
    endtask : rd_chk

    // Level outputs; called at least two edges after the last write
    task automatic out_chk();
        chk({io_limit_high_half, io_base_high_half}, exp_rd(8'h32) << 16 | exp_rd(8'h30));
        chk({29'h0, vga_forward_enable, secondary_hot_reset, irq},
            {29'h0, m_ctrl[3], m_ctrl[6], |(m_st & m_en)});
    endtask : out_chk

    // One secondary event pulse; reports and irq checked on their cycles
    task automatic ev(input int i);
        logic fwd;
        fwd = m_ctrl[1] && (cmd_serr_enable || devctl_err_report_enable);
        @(posedge clk_sys);
        ev_v[i] <= 1'b1;
        @(posedge clk_sys);
        ev_v <= 4'h0;
        #1;
        chk({28'h0, fwd_err_fatal, fwd_err_nonfatal, fwd_err_cor, poison_report},
            {28'h0, fwd && i == 3, fwd && i == 2, fwd && i == 1, m_ctrl[0] && i == 0});
        if (i == 0 && m_ctrl[0])
            m_st[0] = 1'b1;
        if (i != 0 && fwd)
            m_st[1] = 1'b1;
        @(posedge clk_sys);
        #1;
        chk({31'h0, irq}, {31'h0, |(m_st & m_en)});
    endtask : ev

    // ------------------------------------------------------------------------
    // Main sequence
    // ------------------------------------------------------------------------
    initial
    begin
        addrs = '{8'h30, 8'h32, 8'h34, 8'h38, 8'h3c, 8'h3d, 8'h3e, 8'h80, 8'h84, 8'h88,
                  8'h40, 8'h31};
        {reg_wr, reg_rd, reg_addr, reg_wdata, ev_v} = '0;
        {cmd_serr_enable, devctl_err_report_enable} = 2'b00;
        io_wide_addressing_flag = 1'b1;
        resetn = 1'b0;
        lfsr_r = 16'd39970;
        {m_lim, m_ctrl, m_line, m_pin, m_st, m_en} = '0;
        m_base = 16'hffff;
        repeat (5) @(posedge clk_sys);
        resetn <= 1'b1;
        // Values after reset, unmapped addresses included
        foreach (addrs[k]) rd_chk(addrs[k]);
        out_chk();
        // Random writes everywhere, all-ones control, then read back
        repeat (3)
        begin
            // pin writes kept to the legal 0..4
            foreach (addrs[k])
                wr(addrs[k], (addrs[k] == OFS_IRQ_PIN_SELECT) ? rnd32() % 32'd5 : rnd32());
            wr(OFS_BRIDGE_CONTROL, 32'hffff_ffff);
            foreach (addrs[k]) rd_chk(addrs[k]);
            out_chk();
        end
        wr(OFS_IRQ_ROUTING_LINE, rnd32());
        rd_chk(OFS_IRQ_ROUTING_LINE);
        // Flag clear: halves read zero, ignore writes, come back later
        @(posedge clk_sys) io_wide_addressing_flag <= 1'b0;
        wr(OFS_IO_WINDOW_BASE_UPPER, 32'h0000_1234);
        wr(OFS_IO_WINDOW_LIMIT_UPPER, 32'h0000_5678);
        rd_chk(OFS_IO_WINDOW_BASE_UPPER);
        rd_chk(OFS_IO_WINDOW_LIMIT_UPPER);
        out_chk();
        @(posedge clk_sys) io_wide_addressing_flag <= 1'b1;
        rd_chk(OFS_IO_WINDOW_BASE_UPPER);
        out_chk();
        // Every gating combination against every event, irq masked in turn
        for (int c = 0; c < 16; c++)
        begin
            @(posedge clk_sys);
            cmd_serr_enable          <= c[2];
            devctl_err_report_enable <= c[3];
            wr(OFS_EVT_CLEAR, 32'h0000_0007);
            wr(OFS_EVT_ENABLE, 32'(c + 1));
            wr(OFS_BRIDGE_CONTROL, {25'h0, c[0], 4'h0, c[1], c[0]});
            for (int i = 0; i < 4; i++) ev(i);
            rd_chk(OFS_EVT_STATUS);
            out_chk();
        end
        // Hot reset level holds across a status clear, then drops
        wr(OFS_EVT_ENABLE, 32'h0000_0004);
        wr(OFS_BRIDGE_CONTROL, 32'h0000_0040);
        rd_chk(OFS_EVT_STATUS);
        out_chk();
        wr(OFS_EVT_CLEAR, 32'h0000_0004);
        rd_chk(OFS_EVT_STATUS);
        out_chk();
        wr(OFS_BRIDGE_CONTROL, 32'h0000_0000);
        rd_chk(OFS_BRIDGE_CONTROL);
        out_chk();
        conclude();
    end
endmodule : bchr_regs_tb_top
